// File: shared/adcf_pkg.sv
// shared constants and types for the converter flag and test-port slice
package adcf_pkg;
    // apb address width in bits
    localparam int unsigned ADDR_W = 8;
    // register word indices, byte address is four times the index
    localparam logic [5:0] IDX_TEST_ZERO = 6'h08;
    localparam logic [5:0] IDX_TEST_ONE  = 6'h09;
    localparam logic [5:0] IDX_DONE_STAT = 6'h0B;
    localparam logic [5:0] IDX_BUF_EN    = 6'h0D;
    localparam logic [5:0] IDX_PIN_PORT  = 6'h0F;
    localparam logic [5:0] IDX_CFG       = 6'h20;
    localparam logic [5:0] IDX_IRQ_STAT  = 6'h21;
    localparam logic [5:0] IDX_IRQ_CLR   = 6'h22;
    localparam logic [5:0] IDX_IRQ_EN    = 6'h23;
    // field positions
    localparam int unsigned SC_BIT   = 0;
    localparam int unsigned FAST_BIT = 0;
    // values after reset
    localparam logic [7:0]  RST_PIN_PORT  = 8'hFF;
    localparam logic [7:0]  RST_TEST_ONE  = 8'h00;
    localparam logic [7:0]  RST_TEST_ZERO = 8'h00;
    localparam logic [7:0]  RST_BUF_EN    = 8'h00;
    localparam logic [15:0] RST_LFSR      = 16'hACE1;
    // channel select codes in special mode
    localparam logic [2:0]  SEL_REF_HIGH  = 3'h4;
    localparam logic [2:0]  SEL_REF_LOW   = 3'h5;
    localparam logic [2:0]  SEL_MIDPOINT  = 3'h6;

    // converter input source, gray ordered
    typedef enum logic [2:0] {
        SRC_EXT      = 3'h0,
        SRC_REF_HIGH = 3'h1,
        SRC_REF_LOW  = 3'h3,
        SRC_MIDPOINT = 3'h2,
        SRC_RESERVED = 3'h6
    } adcf_source_t;

    // routing handed to the analog multiplexer
    typedef struct packed {
        adcf_source_t source;
        logic [2:0]   ext_chan;
    } adcf_route_t;

    // apb request from the master
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } adcf_apb_req_t;

    // apb response from this slave
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } adcf_apb_rsp_t;
endpackage

// File: test/adcf_top_tb.sv
`timescale 1ns/100ps
// self-checking bench for the converter flag and test-port slice
module adcf_top_tb;
    import adcf_pkg::*;
    logic          core_clk;              // bus clock
    logic          rst;                   // async reset
    adcf_apb_req_t apb_req;               // apb request
    adcf_apb_rsp_t apb_rsp;               // apb response
    logic          test_mode;             // special mode
    logic          seq_start;             // sequence start strobe
    logic [2:0]    chan_select;           // channel select
    logic [7:0]    conv_done;             // completion strobes
    logic [7:0]    result_read;           // result read strobes
    logic [7:0]    pad_level;             // pin levels
    logic [7:0]    buffer_on;             // buffer enables out
    logic          special_source_enable; // special mode out
    adcf_route_t   route;                 // mux routing
    logic [7:0]    test_zero_cfg;         // reserved register
    logic [7:0]    conversion_done_flag;  // done flags
    logic          irq;                   // interrupt
    int            miscompares;           // mismatch count
    int            n_compared;            // comparison count
    logic [31:0]   rd;                    // last read data
    logic          er;                    // last error flag
    logic [7:0]    m_flags;               // model flags
    logic [7:0]    m_arm;                 // model armed bits
    logic [7:0]    m_stat;                // model irq status
    logic [7:0]    m_en;                  // model irq enable
    logic [7:0]    m_ben;                 // model buffer enable
    logic          m_fast;                // model fast clear
    int            seed_v;                // seed result
    int            i;                     // loop index

    adcf_top DUT (
        .core_clk              (core_clk),
        .rst                   (rst),
        .apb_req               (apb_req),
        .apb_rsp               (apb_rsp),
        .test_mode             (test_mode),
        .seq_start             (seq_start),
        .chan_select           (chan_select),
        .conv_done             (conv_done),
        .result_read           (result_read),
        .pad_level             (pad_level),
        .buffer_on             (buffer_on),
        .special_source_enable (special_source_enable),
        .route                 (route),
        .test_zero_cfg         (test_zero_cfg),
        .conversion_done_flag  (conversion_done_flag),
        .irq                   (irq)
    );

    // free-running 125 MHz clock
    always #4 core_clk = ~core_clk;

    // report counts and verdict, then stop
    task automatic test_done();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one comparison, reported at once on mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask

    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
        int k;
        @(posedge core_clk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= wr;
        apb_req.paddr   <= {idx, 2'b00};
        apb_req.pwdata  <= wd;
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk);
            if (apb_rsp.pready === 1'b1) break;
        end
        // no answer within bound
        if (k == 20) begin
            miscompares++;
            test_done();
        end
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    // expected mux source from the select coding
    function automatic adcf_source_t exp_src(input logic sc, input logic [2:0] sel);
        if (!sc) return SRC_EXT;
        case (sel)
            SEL_REF_HIGH: return SRC_REF_HIGH;
            SEL_REF_LOW:  return SRC_REF_LOW;
            SEL_MIDPOINT: return SRC_MIDPOINT;
            default:      return SRC_RESERVED;
        endcase
    endfunction

    // strobe completions, result reads and sequence start, then compare flags and irq
    task automatic pulse(input logic [7:0] d, input logic [7:0] r, input logic s);
        logic [7:0] clr;
        @(posedge core_clk);
        conv_done   <= d;
        result_read <= r;
        seq_start   <= s;
        @(posedge core_clk);
        conv_done   <= 8'h00;
        result_read <= 8'h00;
        seq_start   <= 1'b0;
        clr     = s ? 8'hFF : (m_fast ? r : (r & m_arm));
        m_flags = (m_flags & ~clr) | d;
        // only a clearing event drops an arming, a bare completion keeps it
        m_arm   = m_arm & ~clr;
        m_stat  = m_stat | d;
        @(posedge core_clk);
        chk(conversion_done_flag, m_flags);
        @(posedge core_clk);
        chk(irq, |(m_stat & m_en));
    endtask

    // status read that arms the flags it shows
    task automatic rd_status();
        apb(1'b0, IDX_DONE_STAT, 32'h0);
        chk(rd, {24'h0, m_flags});
        m_arm = m_arm | m_flags;
    endtask

    // cut a hang short
    initial begin
        repeat (50000) @(posedge core_clk);
        miscompares++;
        test_done();
    end

    // main sequence
    initial begin
        core_clk    = 1'b0;
        rst         = 1'b1;
        apb_req     = '0;
        test_mode   = 1'b0;
        seq_start   = 1'b0;
        chan_select = 3'h0;
        conv_done   = 8'h00;
        result_read = 8'h00;
        pad_level   = 8'h00;
        m_flags = 8'h00;
        m_arm   = 8'h00;
        m_stat  = 8'h00;
        m_en    = 8'h00;
        m_fast  = 1'b0;
        miscompares = 0;
        n_compared  = 0;
        seed_v = $urandom(32'h5d0ab6e8);
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        // values after reset
        apb(1'b0, IDX_PIN_PORT, 32'h0);
        chk(rd, 32'h000000FF);
        chk(er, 1'b0);
        apb(1'b0, IDX_BUF_EN, 32'h0);
        chk(rd, 32'h0);
        chk(conversion_done_flag, 8'h00);
        // unmapped address is refused
        apb(1'b0, 6'h3F, 32'h0);
        chk(er, 1'b1);
        // buffer enables and pin port with random pins
        for (i = 0; i < 8; i++) begin
            m_ben = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            pad_level <= 8'($urandom);
            apb(1'b1, IDX_BUF_EN, {24'h0, m_ben});
            apb(1'b0, IDX_BUF_EN, 32'h0);
            chk(rd, {24'h0, m_ben});
            chk(buffer_on, m_ben);
            apb(1'b1, IDX_PIN_PORT, 32'h0);
            apb(1'b0, IDX_PIN_PORT, 32'h0);
            chk(rd, {24'h0, (pad_level & m_ben) | ~m_ben});
        end
        // special enable and every select code in both modes
        for (i = 0; i < 16; i++) begin
            apb(1'b1, IDX_TEST_ONE, {31'h0, i[3]});
            chan_select <= i[2:0];
            repeat (2) @(posedge core_clk);
            chk(special_source_enable, i[3]);
            chk(route.source, exp_src(i[3], i[2:0]));
            if (!i[3]) chk(route.ext_chan, i[2:0]);
            apb(1'b0, IDX_TEST_ONE, 32'h0);
            chk(rd[5:0], {5'h0, i[3]});
        end
        apb(1'b1, IDX_TEST_ONE, 32'h0);
        // reserved register writes only in special mode, looked at one edge after completion
        apb(1'b1, IDX_TEST_ZERO, 32'h5A);
        @(posedge core_clk);
        chk(test_zero_cfg, 8'h00);
        test_mode <= 1'b1;
        apb(1'b1, IDX_TEST_ZERO, 32'hA5);
        @(posedge core_clk);
        chk(test_zero_cfg, 8'hA5);
        test_mode <= 1'b0;
        // slow clearing with status write ignored
        m_en = 8'h0F;
        apb(1'b1, IDX_IRQ_EN, 32'h0F);
        pulse(8'h03, 8'h00, 1'b0);
        apb(1'b1, IDX_DONE_STAT, 32'hFF);
        @(posedge core_clk);
        chk(conversion_done_flag, m_flags);
        pulse(8'h00, 8'h01, 1'b0);
        rd_status();
        pulse(8'h00, 8'h03, 1'b0);
        // completion in the clearing cycle wins and disarms
        pulse(8'h04, 8'h00, 1'b0);
        rd_status();
        pulse(8'h04, 8'h04, 1'b0);
        pulse(8'h00, 8'h04, 1'b0);
        // interrupt status, clear and mask
        apb(1'b0, IDX_IRQ_STAT, 32'h0);
        chk(rd, {24'h0, m_stat});
        apb(1'b1, IDX_IRQ_CLR, 32'hFF);
        m_stat = 8'h00;
        repeat (2) @(posedge core_clk);
        chk(irq, 1'b0);
        pulse(8'h80, 8'h00, 1'b0);
        m_en = 8'h80;
        apb(1'b1, IDX_IRQ_EN, 32'h80);
        repeat (2) @(posedge core_clk);
        chk(irq, 1'b1);
        apb(1'b0, IDX_IRQ_CLR, 32'h0);
        chk(rd, 32'h0);
        // fast clearing, fixed then random
        m_fast = 1'b1;
        apb(1'b1, IDX_CFG, 32'h1);
        pulse(8'hF0, 8'h00, 1'b0);
        pulse(8'h00, 8'h30, 1'b0);
        for (i = 0; i < 6; i++) begin
            pulse(8'($urandom), 8'($urandom), 1'b0);
        end
        // sequence start clears every flag
        pulse(8'hFF, 8'h00, 1'b0);
        pulse(8'h00, 8'h00, 1'b1);
        test_done();
    end
endmodule

// File: verilog/adcf_flag_bank.sv
`timescale 1ns/100ps
// eight conversion done flags with their clearing rules
module adcf_flag_bank (
    input  logic       core_clk,
    input  logic       rst,
    input  logic [7:0] set_pulse,
    input  logic       seq_clear,
    input  logic [7:0] arm_mask,
    input  logic [7:0] res_read,
    input  logic       fast_clear,
    output logic [7:0] flags_q
);
    import adcf_pkg::*;

    logic [7:0] armed_q; // status read has shown this flag set
    logic [7:0] clr;     // clearing event per flag

    // one cell per flag
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_cell
            assign clr[i] = seq_clear | (res_read[i] & (fast_clear | armed_q[i]));
            // flag register, set beats clear
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    flags_q[i] <= 1'b0;
                end else begin
                    flags_q[i] <= set_pulse[i] | (flags_q[i] & ~clr[i]);
                end
            end
            // arming by a status read that saw the flag
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    armed_q[i] <= 1'b0;
                end else begin
                    armed_q[i] <= ~clr[i] & (armed_q[i] | (arm_mask[i] & flags_q[i]));
                end
            end
        end
    endgenerate

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_set_wins;
        (set_pulse != 8'h00) |=> ((flags_q & $past(set_pulse)) == $past(set_pulse));
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("completion lost");

    property p_seq_clear;
        (seq_clear && set_pulse == 8'h00) |=> (flags_q == 8'h00);
    endproperty
    a_seq_clear: assert property (p_seq_clear) else $error("sequence start left a flag");

    property p_fast_clear;
        (fast_clear && (res_read & flags_q & ~set_pulse) != 8'h00)
            |=> ((flags_q & $past(res_read) & ~$past(set_pulse)) == 8'h00);
    endproperty
    a_fast_clear: assert property (p_fast_clear) else $error("fast clear missed");

    property p_need_status;
        (!fast_clear && !seq_clear && armed_q == 8'h00)
            |=> (($past(flags_q) & ~flags_q) == 8'h00);
    endproperty
    a_need_status: assert property (p_need_status) else $error("flag cleared unarmed");
endmodule

// File: verilog/adcf_top.sv
`timescale 1ns/100ps
// Summary of operation
// - reserved test reads random, writes special-only
// - test one top two bits read random
// - test one bit zero enables special sources
// - special codes pick high, low, midpoint
// - done status readable, writes change nothing
// - conversion x completion sets flag x
// - sequence start clears all flags except those completing in the same cycle
// - slow mode: status read then result read
// - fast mode: result read alone clears
// - buffer enable bit gates pin x
// - set enable keeps buffer on always
// - enabled pin reads its sampled level
// - disabled pin reads one
// - port resets to ones, ignores writes
// - normal mode selects external input binary
module adcf_top (
    input  logic                   core_clk,
    input  logic                   rst,
    input  adcf_pkg::adcf_apb_req_t apb_req,
    output adcf_pkg::adcf_apb_rsp_t apb_rsp,
    input  logic                   test_mode,
    input  logic                   seq_start,
    input  logic [2:0]             chan_select,
    input  logic [7:0]             conv_done,
    input  logic [7:0]             result_read,
    input  logic [7:0]             pad_level,
    output logic [7:0]             buffer_on,
    output logic                   special_source_enable,
    output adcf_pkg::adcf_route_t  route,
    output logic [7:0]             test_zero_cfg,
    output logic [7:0]             conversion_done_flag,
    output logic                   irq
);
    import adcf_pkg::*;

    // registers
    adcf_apb_rsp_t rsp_q;      // registered bus answer
    logic [7:0]    test_zero_q; // reserved test contents
    logic [7:0]    test_one_q;  // special channel test contents
    logic [7:0]    buf_en_q;    // digital buffer enables
    logic [7:0]    pin_q;       // sampled pin levels
    logic          fast_q;      // fast flag clearing
    logic [7:0]    irq_stat_q;  // sticky completion events
    logic [7:0]    irq_en_q;    // interrupt enables
    logic          irq_q;       // interrupt output
    logic [15:0]   lfsr_q;      // source of unpredictable data
    adcf_route_t   route_q;     // registered routing
    logic [7:0]    flags_q;     // done flags from the bank

    // combinational
    logic          setup;       // apb setup cycle
    logic          done;        // apb completion edge
    logic          wr;          // completing write
    logic          rd;          // completing read
    logic [31:0]   rd_d;        // read data for the address
    logic          err_d;       // unmapped address
    logic [7:0]    arm_mask;    // flags seen by a status read
    logic [7:0]    clr_mask;    // interrupt clear bits

    // address decode, used for reads and writes
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [5:0] idx);
        reg_hit = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
    endfunction

    // routing decode for the analog multiplexer
    function automatic adcf_route_t route_decode(input logic sc,
                                                 input logic [2:0] sel);
        adcf_route_t r;
        r.ext_chan = sel;
        r.source   = SRC_EXT;
        if (sc) begin
            // special source codes
            case (sel)
                SEL_REF_HIGH: r.source = SRC_REF_HIGH;
                SEL_REF_LOW:  r.source = SRC_REF_LOW;
                SEL_MIDPOINT: r.source = SRC_MIDPOINT;
                default:      r.source = SRC_RESERVED;
            endcase
        end
        route_decode = r;
    endfunction

    // bus phases
    assign setup = apb_req.psel & ~apb_req.penable;
    assign done  = apb_req.psel & apb_req.penable & rsp_q.pready;
    assign wr    = done & apb_req.pwrite;
    assign rd    = done & ~apb_req.pwrite;

    // read mux, selected from the address
    always_comb begin
        rd_d  = 32'h0000_0000;
        err_d = 1'b0;
        if (reg_hit(apb_req.paddr, IDX_TEST_ZERO)) begin
            rd_d[7:0] = lfsr_q[7:0];
        end else if (reg_hit(apb_req.paddr, IDX_TEST_ONE)) begin
            rd_d[7:0] = {lfsr_q[9:8], test_one_q[5:0]};
        end else if (reg_hit(apb_req.paddr, IDX_DONE_STAT)) begin
            rd_d[7:0] = flags_q;
        end else if (reg_hit(apb_req.paddr, IDX_BUF_EN)) begin
            rd_d[7:0] = buf_en_q;
        end else if (reg_hit(apb_req.paddr, IDX_PIN_PORT)) begin
            rd_d[7:0] = pin_q;
        end else if (reg_hit(apb_req.paddr, IDX_CFG)) begin
            rd_d[FAST_BIT] = fast_q;
        end else if (reg_hit(apb_req.paddr, IDX_IRQ_STAT)) begin
            rd_d[7:0] = irq_stat_q;
        end else if (reg_hit(apb_req.paddr, IDX_IRQ_CLR)) begin
            // write-only, reads zero
            rd_d = 32'h0000_0000;
        end else if (reg_hit(apb_req.paddr, IDX_IRQ_EN)) begin
            rd_d[7:0] = irq_en_q;
        end else begin
            // unmapped address
            err_d = 1'b1;
        end
    end

    // bus answer: ready in the first access cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rsp_q <= '0;
        end else begin
            rsp_q.pready  <= setup;
            rsp_q.pslverr <= setup & err_d;
            if (setup) begin
                rsp_q.prdata <= rd_d;
            end
        end
    end

    // free running lfsr for unpredictable read bits
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lfsr_q <= RST_LFSR;
        end else begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        end
    end

    // reserved test register, writable only in special mode
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            test_zero_q <= RST_TEST_ZERO;
        end else if (wr && test_mode && reg_hit(apb_req.paddr, IDX_TEST_ZERO)) begin
            test_zero_q <= apb_req.pwdata[7:0];
        end
    end

    // special channel test register, writable any time
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            test_one_q <= RST_TEST_ONE;
        end else if (wr && reg_hit(apb_req.paddr, IDX_TEST_ONE)) begin
            test_one_q <= apb_req.pwdata[7:0];
        end
    end

    // buffer enables and fast clear configuration
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            buf_en_q <= RST_BUF_EN;
            fast_q   <= 1'b0;
        end else if (wr) begin
            if (reg_hit(apb_req.paddr, IDX_BUF_EN)) begin
                buf_en_q <= apb_req.pwdata[7:0];
            end
            if (reg_hit(apb_req.paddr, IDX_CFG)) begin
                fast_q <= apb_req.pwdata[FAST_BIT];
            end
        end
    end

    // pin sampling, writes never reach it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_q <= RST_PIN_PORT;
        end else begin
            pin_q <= (pad_level & buf_en_q) | ~buf_en_q;
        end
    end

    // routing toward the analog multiplexer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            route_q <= '0;
        end else begin
            route_q <= route_decode(test_one_q[SC_BIT], chan_select);
        end
    end

    // flags seen by a completing status read
    assign arm_mask = (rd && reg_hit(apb_req.paddr, IDX_DONE_STAT)) ? rsp_q.prdata[7:0] : 8'h00;

    // done flags and their clearing
    adcf_flag_bank u_flags (
        .core_clk   (core_clk),
        .rst        (rst),
        .set_pulse  (conv_done),
        .seq_clear  (seq_start),
        .arm_mask   (arm_mask),
        .res_read   (result_read),
        .fast_clear (fast_q),
        .flags_q    (flags_q)
    );

    // interrupt clear bits from a write
    assign clr_mask = (wr && reg_hit(apb_req.paddr, IDX_IRQ_CLR)) ? apb_req.pwdata[7:0] : 8'h00;

    // sticky interrupt status, set beats clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= 8'h00;
        end else begin
            irq_stat_q <= (irq_stat_q & ~clr_mask) | conv_done;
        end
    end

    // interrupt enables
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_en_q <= 8'h00;
        end else if (wr && reg_hit(apb_req.paddr, IDX_IRQ_EN)) begin
            irq_en_q <= apb_req.pwdata[7:0];
        end
    end

    // level interrupt
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_en_q);
        end
    end

    // outputs, all from flip-flops
    assign apb_rsp               = rsp_q;
    assign buffer_on             = buf_en_q;
    assign special_source_enable = test_one_q[SC_BIT];
    assign route                 = route_q;
    assign test_zero_cfg         = test_zero_q;
    assign conversion_done_flag  = flags_q;
    assign irq                   = irq_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_setup_test_one;
        setup && !apb_req.pwrite && reg_hit(apb_req.paddr, IDX_TEST_ONE);
    endsequence

    property p_test_one_read;
        s_setup_test_one |=> rsp_q.pready && rsp_q.prdata[5:0] == $past(test_one_q[5:0]);
    endproperty
    a_test_one_read: assert property (p_test_one_read) else $error("test one read wrong");

    property p_test_zero_locked;
        (wr && !test_mode && reg_hit(apb_req.paddr, IDX_TEST_ZERO)) |=> $stable(test_zero_q);
    endproperty
    a_test_zero_locked: assert property (p_test_zero_locked) else $error("normal write took");

    property p_test_zero_write;
        (wr && test_mode && reg_hit(apb_req.paddr, IDX_TEST_ZERO))
            |=> test_zero_q == $past(apb_req.pwdata[7:0]);
    endproperty
    a_test_zero_write: assert property (p_test_zero_write) else $error("special write lost");

    property p_pin_disabled;
        1'b1 |=> ((pin_q | $past(buf_en_q)) == 8'hFF);
    endproperty
    a_pin_disabled: assert property (p_pin_disabled) else $error("disabled pin not one");

    property p_pin_level;
        1'b1 |=> ((pin_q & $past(buf_en_q)) == ($past(pad_level) & $past(buf_en_q)));
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("pin level wrong");

    property p_route_ext;
        !test_one_q[SC_BIT] |=> route_q.source == SRC_EXT && route_q.ext_chan == $past(chan_select);
    endproperty
    a_route_ext: assert property (p_route_ext) else $error("external route wrong");

    property p_route_mid;
        (test_one_q[SC_BIT] && chan_select == SEL_MIDPOINT) |=> route_q.source == SRC_MIDPOINT;
    endproperty
    a_route_mid: assert property (p_route_mid) else $error("midpoint route wrong");

    property p_route_high;
        (test_one_q[SC_BIT] && chan_select == SEL_REF_HIGH) |=> route_q.source == SRC_REF_HIGH;
    endproperty
    a_route_high: assert property (p_route_high) else $error("high route wrong");

    property p_status_ro;
        (wr && reg_hit(apb_req.paddr, IDX_DONE_STAT) && conv_done == 8'h00 && !seq_start
            && result_read == 8'h00) |=> $stable(flags_q);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write changed flags");

    property p_irq_raise;
        ((conv_done & irq_en_q) != 8'h00 && !(wr && reg_hit(apb_req.paddr, IDX_IRQ_EN))) |=> ##1 irq_q;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");
endmodule
